// ==== src/sram_tap_map.svh ====
// shared constants of the boundary scan test port
// assumes inclusion by bare name from the package and the design modules
`ifndef SRAM_TAP_MAP_SVH
`define SRAM_TAP_MAP_SVH

`define IR_WIDTH 3
`define IR_CAPTURE_PATTERN 2'h1
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE_Z 3'h2
`define IR_SAMPLE 3'h4
`define IR_BYPASS 3'h7
`define ID_WIDTH 32
// identity value is arbitrary; bit 0 marks an identification register
`define ID_CODE_X36 32'h0ACE5A5B
`define ID_CODE_X18 32'h0ACE3A5B
`define BSR_LEN_X36 70
`define BSR_LEN_X18 51
`define RESET_TMS_EDGES 5

`endif

// ==== src/sram_tap_pkg.sv ====
// types shared by the test port modules
// assumes sram_tap_map.svh on the include path
`include "sram_tap_map.svh"
package sram_tap_pkg;
  typedef enum logic [3:0] {
    TestLogicReset, RunIdle, SelectDr, CaptureDr, ShiftDr, Exit1Dr, PauseDr, Exit2Dr,
    UpdateDr, SelectIr, CaptureIr, ShiftIr, Exit1Ir, PauseIr, Exit2Ir, UpdateIr
  } tap_state_e;
endpackage

// ==== src/tap_edge_if.sv ====
// sampled link pins and their detected edges, between top and state machine
// assumes a single clk_sys domain
`timescale 1ns/1ns
interface tap_edge_if;
  logic tckRise;
  logic tmsLevel;
  modport src (output tckRise, output tmsLevel);
  modport dst (input tckRise, input tmsLevel);
endinterface

// ==== src/tap_fsm.sv ====
// sixteen-state test controller, advanced on each detected test clock rise
// assumes edges come from the top-level synchronisers
`timescale 1ns/1ns
module tap_fsm
  import sram_tap_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  tap_edge_if.dst edges,
  output tap_state_e state
);
  tap_state_e state_q;
  tap_state_e state_d;

  assign state = state_q;

  always_comb begin
    state_d = state_q;
    case (state_q) // RQ24
      TestLogicReset: state_d = edges.tmsLevel ? TestLogicReset : RunIdle;
      RunIdle: state_d = edges.tmsLevel ? SelectDr : RunIdle;
      SelectDr: state_d = edges.tmsLevel ? SelectIr : CaptureDr;
      CaptureDr: state_d = edges.tmsLevel ? Exit1Dr : ShiftDr;
      ShiftDr: state_d = edges.tmsLevel ? Exit1Dr : ShiftDr;
      Exit1Dr: state_d = edges.tmsLevel ? UpdateDr : PauseDr;
      PauseDr: state_d = edges.tmsLevel ? Exit2Dr : PauseDr;
      Exit2Dr: state_d = edges.tmsLevel ? UpdateDr : ShiftDr;
      UpdateDr: state_d = edges.tmsLevel ? SelectDr : RunIdle;
      SelectIr: state_d = edges.tmsLevel ? TestLogicReset : CaptureIr; // RQ5
      CaptureIr: state_d = edges.tmsLevel ? Exit1Ir : ShiftIr;
      ShiftIr: state_d = edges.tmsLevel ? Exit1Ir : ShiftIr;
      Exit1Ir: state_d = edges.tmsLevel ? UpdateIr : PauseIr;
      PauseIr: state_d = edges.tmsLevel ? Exit2Ir : PauseIr;
      Exit2Ir: state_d = edges.tmsLevel ? UpdateIr : ShiftIr;
      UpdateIr: state_d = edges.tmsLevel ? SelectDr : RunIdle;
      default: state_d = TestLogicReset;
    endcase
  end

  // power-up lands in the reset state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= TestLogicReset; // RQ6
    end else if (edges.tckRise) begin
      state_q <= state_d; // RQ3
    end
  end
endmodule // tap_fsm

// ==== src/sram_boundary_scan_tap.sv ====
// boundary scan test access port of a burst memory, oversampling the test clock
// assumes clk_sys at 10 MHz or more faster than the test clock; pin ring on pinRing
//
// Contract
// RQ1 - unused port: the outside holds the test clock low, so nothing advances.
// RQ2 - unconnected mode select and data input read as logic high.
// RQ3 - mode select and data sampled on clock rise; data out changes on fall.
// RQ4 - serial data enters at the top bit and leaves from bit zero.
// RQ5 - five rises with mode select high reach reset; memory undisturbed.
// RQ6 - power-up resets the controller, so data out starts undriven.
// RQ7 - data out driven only while a register shifts.
// RQ8 - the instruction selects exactly one register between data in and out.
// RQ9 - three-bit instruction, preset to identification read at reset.
// RQ10 - instruction capture loads 01 into the two lowest bits.
// RQ11 - bypass is one bit, cleared when bypass runs.
// RQ12 - boundary chain is 70 bits wide-mode, 51 bits narrow-mode.
// RQ13 - chain holds cells for unconnected reserved package positions too.
// RQ14 - data capture snapshots the pin ring; data shift connects the chain.
// RQ15 - external test, sample and sample-floated select and capture the chain.
// RQ16 - identification instruction captures a hardwired 32-bit code.
// RQ17 - the outside issues only the five defined codes.
// RQ18 - the port never drives memory pins nor preloads buffers.
// RQ19 - shifted instruction takes effect only through instruction update.
// RQ20 - all-zero instruction acts as sample but floats memory outputs.
// RQ21 - sample-floated connects the chain and floats memory outputs.
// RQ22 - data update under sample has no effect beyond a pause.
// RQ23 - identification bit zero reads one.
// RQ24 - controller follows the standard sixteen-state transitions.
`timescale 1ns/1ns
`include "sram_tap_map.svh"
module sram_boundary_scan_tap
  import sram_tap_pkg::*;
#(
  parameter bit WIDE = 1'b1
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tmsPullEn,
  input wire logic tdi,
  input wire logic tdiPullEn,
  input wire logic [`BSR_LEN_X36-1:0] pinRing,
  output logic tdo,
  output logic tdoOe,
  output logic memOutFloat
);
  localparam int BSR_LEN = WIDE ? `BSR_LEN_X36 : `BSR_LEN_X18; // RQ12
  localparam logic [`ID_WIDTH-1:0] ID_CODE = WIDE ? `ID_CODE_X36 : `ID_CODE_X18;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [1:0] tckSync_q;
  logic [1:0] tmsSync_q;
  logic [1:0] tdiSync_q;
  logic tckPrev_q;
  logic tmsPin;
  logic tdiPin;
  logic tckFall;
  tap_state_e state;
  tap_edge_if edges();

  // an undriven input reads high, as the internal pull-up would make it
  assign tmsPin = tmsPullEn ? 1'b1 : tms; // RQ2
  assign tdiPin = tdiPullEn ? 1'b1 : tdi; // RQ2

  // reset leaves the mode select and data synchronisers high and the test clock one low so a floating port idles in reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tckSync_q <= 2'h0;
      tmsSync_q <= 2'h3;
      tdiSync_q <= 2'h3;
      tckPrev_q <= 1'b0;
    end else begin
      tckSync_q <= {tckSync_q[0], tck};
      tmsSync_q <= {tmsSync_q[0], tmsPin};
      tdiSync_q <= {tdiSync_q[0], tdiPin};
      tckPrev_q <= tckSync_q[1];
    end
  end

  assign edges.tckRise = tckSync_q[1] & ~tckPrev_q; // RQ3
  assign edges.tmsLevel = tmsSync_q[1];
  assign tckFall = ~tckSync_q[1] & tckPrev_q;

  tap_fsm fsm (
    .clk_sys(clk_sys),
    .rst(rst),
    .edges(edges),
    .state(state)
  );

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  logic [`IR_WIDTH-1:0] irShift_q;
  logic [`IR_WIDTH-1:0] ir_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irShift_q <= `IR_IDCODE;
    end else if (edges.tckRise) begin
      case (state)
        CaptureIr: irShift_q <= {ir_q[`IR_WIDTH-1], `IR_CAPTURE_PATTERN}; // RQ10
        ShiftIr: irShift_q <= {tdiSync_q[1], irShift_q[`IR_WIDTH-1:1]}; // RQ4
        default: irShift_q <= irShift_q;
      endcase
    end
  end

  // preset as soon as the reset state is entered, not at the rise after it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ir_q <= `IR_IDCODE; // RQ9
    end else if (state == TestLogicReset) begin
      ir_q <= `IR_IDCODE; // RQ9
    end else if (edges.tckRise && state == UpdateIr) begin
      ir_q <= irShift_q; // RQ19
    end
  end

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  logic selBsr;
  logic selId;
  logic selBypass;

  // reserved codes fall to bypass so that one register always stands in the path
  always_comb begin
    selBsr = 1'b0;
    selId = 1'b0;
    selBypass = 1'b0;
    case (ir_q) // RQ8
      `IR_EXTEST, `IR_SAMPLE, `IR_SAMPLE_Z: selBsr = 1'b1; // RQ15
      `IR_IDCODE: selId = 1'b1;
      default: selBypass = 1'b1; // RQ17
    endcase
  end

  // only a float request leaves this port; no pin value is ever driven into the memory
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      memOutFloat <= 1'b0;
    end else begin
      memOutFloat <= (ir_q == `IR_EXTEST) || (ir_q == `IR_SAMPLE_Z); // RQ20 RQ21 RQ18
    end
  end

  // ----------------------------------------------------------------
  // data registers
  // ----------------------------------------------------------------
  logic [BSR_LEN-1:0] bsr_q;
  logic [`ID_WIDTH-1:0] id_q;
  logic bypass_q;

  // pinRing includes cells for reserved unconnected package positions
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bsr_q <= '0;
    end else if (edges.tckRise && selBsr) begin
      case (state)
        CaptureDr: bsr_q <= pinRing[BSR_LEN-1:0]; // RQ14 RQ13
        ShiftDr: bsr_q <= {tdiSync_q[1], bsr_q[BSR_LEN-1:1]}; // RQ4 RQ14
        // update has no preload, so it holds like a pause
        default: bsr_q <= bsr_q; // RQ22 RQ18
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      id_q <= '0;
    end else if (edges.tckRise && selId) begin
      case (state)
        CaptureDr: id_q <= {ID_CODE[`ID_WIDTH-1:1], 1'b1}; // RQ16 RQ23
        ShiftDr: id_q <= {tdiSync_q[1], id_q[`ID_WIDTH-1:1]}; // RQ4
        default: id_q <= id_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bypass_q <= 1'b0;
    end else if (edges.tckRise && selBypass) begin
      case (state)
        CaptureDr: bypass_q <= 1'b0; // RQ11
        ShiftDr: bypass_q <= tdiSync_q[1];
        default: bypass_q <= bypass_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial output, changed on the falling test clock edge
  // ----------------------------------------------------------------
  logic tdoNext;

  always_comb begin
    if (state == ShiftIr) begin
      tdoNext = irShift_q[0];
    end else if (selBsr) begin
      tdoNext = bsr_q[0];
    end else if (selId) begin
      tdoNext = id_q[0];
    end else begin
      tdoNext = bypass_q;
    end
  end

  // with the test clock held low no fall ever comes and the port stays quiet
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
      tdoOe <= 1'b0; // RQ6
    end else if (tckFall) begin
      tdo <= tdoNext; // RQ3 RQ1
      tdoOe <= (state == ShiftIr) || (state == ShiftDr); // RQ7
    end
  end
endmodule // sram_boundary_scan_tap

// ==== verif/sram_tap_asserts.sv ====
// pin-level assertions for the boundary scan test port
// assumes tck is held at least four clk_sys cycles in each half period
`timescale 1ns/1ns
`include "sram_tap_map.svh"
module sram_tap_asserts #(
  parameter bit WIDE = 1'b1
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tmsPullEn,
  input wire logic tdi,
  input wire logic tdiPullEn,
  input wire logic [`BSR_LEN_X36-1:0] pinRing,
  input wire logic tdo,
  input wire logic tdoOe,
  input wire logic memOutFloat
);
  logic tckPrev_q;
  logic lastTms_q;
  logic [2:0] highRun_q;
  logic [2:0] riseAge_q;
  wire tmsEff = tms | tmsPullEn;
  wire tckRise = tck & ~tckPrev_q;
  // checker sees the raw pin, ahead of the design's synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tckPrev_q <= 1'b0;
      lastTms_q <= 1'b1;
      highRun_q <= 3'h0;
      riseAge_q <= 3'h7;
    end else begin
      tckPrev_q <= tck;
      if (tckRise) lastTms_q <= tmsEff;
      if (tckRise) highRun_q <= tmsEff ? highRun_q + 3'(highRun_q != 3'h7) : 3'h0;
      riseAge_q <= tckRise ? 3'h0 : riseAge_q + 3'(riseAge_q != 3'h7);
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  tdo_low_phase_a: assert property ($changed(tdo) |-> !tck)
    else $error("tdo moved while the test clock was high");
  oe_low_phase_a: assert property ($changed(tdoOe) |-> !tck)
    else $error("tdoOe moved while the test clock was high");
  reset_quiet_a: assert property ($fell(rst) |-> !tdoOe && !memOutFloat)
    else $error("outputs active right after reset");
  tms_reset_a: assert property (highRun_q >= 3'h5 && $fell(tck) |-> ##[1:8] (!memOutFloat && !tdoOe))
    else $error("five high mode-select rises did not reset the port");
  oe_enter_shift_a: assert property ($rose(tdoOe) |-> !lastTms_q)
    else $error("tdoOe rose without a shift entry");
  oe_leave_shift_a: assert property ($fell(tdoOe) |-> lastTms_q)
    else $error("tdoOe fell without a shift exit");
  float_after_rise_a: assert property ($changed(memOutFloat) |-> riseAge_q <= 3'h6)
    else $error("memOutFloat changed away from a test clock rise");
  float_not_shift_a: assert property ($changed(memOutFloat) |-> !tdoOe)
    else $error("instruction changed while shifting");
endmodule // sram_tap_asserts

bind sram_boundary_scan_tap sram_tap_asserts #(.WIDE(WIDE)) u_sram_tap_asserts (
  .clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms), .tmsPullEn(tmsPullEn), .tdi(tdi),
  .tdiPullEn(tdiPullEn), .pinRing(pinRing), .tdo(tdo), .tdoOe(tdoOe), .memOutFloat(memOutFloat));

// ==== verif/jtag_host_model.sv ====
// behavioural board test controller: drives tck, tms, tdi and samples tdo
// assumes it is stepped by the bench one test clock period at a time
`timescale 1ns/1ns
module jtag_host_model (
  input wire logic clk_sys,
  input wire logic tdo,
  input wire logic tdoOe,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic bitStb,
  output logic bitVal
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    bitStb = 1'b0;
    bitVal = 1'b0;
  end
  // one 800 ns period; tck rests low between steps so nothing advances
  task automatic step(input logic tmsBit, input logic tdiBit, input logic chk);
    @(negedge clk_sys);
    tms = tmsBit;
    tdi = tdiBit;
    repeat (3) @(negedge clk_sys);
    bitVal = tdoOe ? tdo : 1'bx;
    bitStb = chk;
    tck = 1'b1;
    @(negedge clk_sys);
    bitStb = 1'b0;
    repeat (3) @(negedge clk_sys);
    tck = 1'b0;
  endtask
endmodule // jtag_host_model

// ==== verif/testbench.sv ====
// self-checking bench for the boundary scan test port, wide configuration
// assumes the partner model steps the link; tdo is checked against a queue, memOutFloat against direct expectations
`timescale 1ns/1ns
`include "sram_tap_map.svh"
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, tmsPullEn = 1'b0, tdiPullEn = 1'b0;
  logic tck, tms, tdi, tdo, tdoOe, memOutFloat, bitStb, bitVal;
  logic [69:0] pinRing = '0;
  logic [2:0] curIr;
  logic [2:0] codes [6] = '{3'h7, 3'h1, 3'h1, 3'h2, 3'h4, 3'h0};
  logic expQ[$];
  int err_count = 0, n_compared = 0, cycles = 0;
  always #50 clk_sys = ~clk_sys;
  sram_boundary_scan_tap #(.WIDE(1'b1)) u_sram_boundary_scan_tap (.clk_sys(clk_sys),
    .rst(rst), .tck(tck), .tms(tms), .tmsPullEn(tmsPullEn), .tdi(tdi), .tdiPullEn(tdiPullEn),
    .pinRing(pinRing), .tdo(tdo), .tdoOe(tdoOe), .memOutFloat(memOutFloat));
  jtag_host_model u_jtag_host_model (.clk_sys(clk_sys), .tdo(tdo), .tdoOe(tdoOe), .tck(tck),
    .tms(tms), .tdi(tdi), .bitStb(bitStb), .bitVal(bitVal));
  task automatic cmp(input string what, input logic expv, input logic got);
    n_compared++;
    if (got !== expv) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, expv, got);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (bitStb === 1'b1) cmp("tdo", expQ.pop_front(), bitVal);
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      conclude();
    end
  end
  // from idle: capture, shift n captured bits plus extra fed-through bits, back to idle
  task automatic scan(input bit isIr, input int n, input int extra, input logic [69:0] cap,
      input logic [2:0] code);
    logic q[$];
    int i;
    logic b;
    u_jtag_host_model.step(1'b1, 1'b0, 1'b0);
    if (isIr) u_jtag_host_model.step(1'b1, 1'b0, 1'b0);
    u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
    u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
    for (i = 0; i < n + extra; i++) begin
      if (isIr) b = code[i];
      else begin
        b = 1'($urandom);
        tdiPullEn = 1'($urandom);
      end
      if (i < n) expQ.push_back(cap[i]);
      else expQ.push_back(q.pop_front());
      q.push_back(b | tdiPullEn);
      u_jtag_host_model.step(i == n + extra - 1, b, 1'b1);
    end
    tdiPullEn = 1'b0;
    u_jtag_host_model.step(1'b1, 1'b0, 1'b0);
    u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
  endtask
  // ----
  // scenarios
  // ----
  initial begin
    void'($urandom(32'h2EA468A5));
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    cmp("memOutFloat", 1'b0, memOutFloat);
    u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
    curIr = `IR_IDCODE;
    scan(1'b0, 32, 8, 70'(`ID_CODE_X36), 3'h0);
    $display("test power-up identification done");
    foreach (codes[k]) begin
      scan(1'b1, 3, 0, {67'h0, curIr[2], 2'b01}, codes[k]);
      curIr = codes[k];
      repeat (2) @(negedge clk_sys);
      cmp("memOutFloat", curIr == 3'h0 || curIr == 3'h2, memOutFloat);
      repeat (2) begin
        pinRing = 70'({$urandom, $urandom, $urandom});
        case (curIr)
          3'h0, 3'h2, 3'h4: scan(1'b0, 70, 8, pinRing, 3'h0);
          3'h1: scan(1'b0, 32, 8, 70'(`ID_CODE_X36), 3'h0);
          default: scan(1'b0, 1, 8, 70'h0, 3'h0);
        endcase
      end
      $display("test instruction %b done", curIr);
    end
    // walk into data shift so that the reset needs all five high rises
    u_jtag_host_model.step(1'b1, 1'b0, 1'b0);
    u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
    u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
    tmsPullEn = 1'b1;
    repeat (5) u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
    tmsPullEn = 1'b0;
    repeat (4) @(negedge clk_sys);
    cmp("memOutFloat", 1'b0, memOutFloat);
    u_jtag_host_model.step(1'b0, 1'b0, 1'b0);
    scan(1'b0, 32, 8, 70'(`ID_CODE_X36), 3'h0);
    $display("test mode-select reset done");
    wait (expQ.size() == 0);
    repeat (4) @(negedge clk_sys);
    conclude();
  end
endmodule // testbench
